// *** hdl/gcc_pkg.sv ***
// package: register map, field positions, reset values and timing for the config bank
package gcc_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL_TWO  = 8'h10;
   localparam logic [7:0] IDX_SETTINGS  = 8'h11;
   localparam logic [7:0] IDX_SYNTH     = 8'h12;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'(IDX_CTRL_TWO * 4);
   localparam logic [7:0] ADDR_SETTINGS = 8'(IDX_SETTINGS * 4);
   localparam logic [7:0] ADDR_SYNTH    = 8'(IDX_SYNTH * 4);

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CTRL_TWO  = 8'h0A;
   localparam logic [7:0] RST_SETTINGS  = 8'h3C;
   localparam logic [7:0] RST_SYNTH     = 8'h02;

   // ----------------------------------------------------------------
   // output_pin_control_two fields
   // ----------------------------------------------------------------
   localparam int POS_OUT_TWO_FUNC   = 5;
   localparam int POS_OUT_ONE_FUNC   = 4;
   localparam int POS_OUT_TWO_DRIVE  = 3;
   localparam int POS_OUT_TWO_GATE   = 1;
   localparam int POS_OUT_TWO_LEVEL  = 0;

   // ----------------------------------------------------------------
   // general_settings fields
   // ----------------------------------------------------------------
   localparam int POS_STARTUP_SCALE  = 7;
   localparam int POS_SHUTDOWN_SCALE = 6;
   localparam int POS_EXT_CLK_PD     = 5;
   localparam int POS_ENABLE_PIN_THREE_PULLDOWN         = 4;
   localparam int POS_ENABLE_PIN_TWO_PULLDOWN         = 3;
   localparam int POS_ENABLE_PIN_ONE_PULLDOWN         = 2;
   localparam int POS_THERMAL_THR    = 1;
   localparam int POS_SPREAD         = 0;

   // ----------------------------------------------------------------
   // clock_synth_control fields
   // ----------------------------------------------------------------
   localparam int POS_PLL_ON         = 6;
   localparam int POS_FRAC_DIV       = 5;
   localparam int POS_FREQ_CODE      = 0;

   // ----------------------------------------------------------------
   // timing: one delay unit is half a millisecond
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS      = 5;
   localparam int DELAY_UNIT_NS      = 500000;
   localparam int DELAY_UNIT_CYCLES  = DELAY_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {GCC_GATE_NONE, GCC_GATE_EN1, GCC_GATE_EN2, GCC_GATE_EN3} gcc_gate_t;

endpackage

// *** hdl/gcc_config_regs.sv ***
// module: output-pin, general settings and clock synthesis configuration registers on APB
//
// Summary of operation
// - pin two select: clock input or output
// - pin one select: power good or output
// - output two drive: push-pull or open-drain
// - gating code ANDs level with enable pin
// - gating code zero uses level bit alone
// - level bit sets output two high/low
// - startup scale: half or whole millisecond steps
// - shutdown scale: half or whole millisecond steps
// - clock input pull-down enable, default on
// - enable pin pull-downs, default on
// - thermal threshold 125 or 140 degrees
// - spread spectrum on/off for all converters
// - synth off forces internal RC oscillator
// - synth on runs in standby and active
// - synth on selects external clock when present
// - synth on pulses event on clock change
// - frequency code n means n+1 MHz
// - defaults loaded from OTP once after reset release
// - startup delay code times selected step
`timescale 1ns/1ps
module gcc_config_regs #(
   parameter int TICK_CYCLES = gcc_pkg::DELAY_UNIT_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic [7:0]  otp_ctrl_two,
   input  wire logic [7:0]  otp_settings,
   input  wire logic [7:0]  otp_synth,
   input  wire logic        enable_pin_one,
   input  wire logic        enable_pin_two,
   input  wire logic        enable_pin_three,
   input  wire logic        power_good_one,
   input  wire logic        general_output_one,
   input  wire logic        ext_clock_present,
   input  wire logic [3:0]  out_two_startup_code,
   input  wire logic [3:0]  out_two_shutdown_code,
   output logic             out_two_pin_out,
   output logic             out_two_pin_oe,
   output logic             out_one_pin_level,
   output logic             ext_clock_pin_pulldown,
   output logic             enable_pin_one_pulldown,
   output logic             enable_pin_two_pulldown,
   output logic             enable_pin_three_pulldown,
   output logic             thermal_warning_threshold,
   output logic             spread_spectrum_on,
   output logic             synth_running,
   output logic             ext_clock_selected,
   output logic             ext_clock_change_pulse,
   output logic [4:0]       ext_clock_freq_code
);

   localparam int TW = $clog2(TICK_CYCLES + 1);

   typedef struct packed {
      logic [7:0]  ctrl_two;
      logic [7:0]  settings;
      logic [7:0]  synth;
      logic        load_pend;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        target;
      logic        level;
      logic        busy;
      logic [4:0]  remain;
      logic [TW-1:0] tick;
      logic        ext_prev;
      logic        evt;
      logic        use_ext;
      logic        pin_out;
      logic        pin_oe;
      logic        pin_one;
   } gcc_state_t;

   gcc_state_t s_q;
   gcc_state_t s_d;

   logic access;
   logic wr_now;
   logic hit_two;
   logic hit_set;
   logic hit_syn;
   logic gated;
   logic scale;
   logic [3:0] code;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d     = s_q;
      access  = psel && penable;
      hit_two = paddr == gcc_pkg::ADDR_CTRL_TWO;
      hit_set = paddr == gcc_pkg::ADDR_SETTINGS;
      hit_syn = paddr == gcc_pkg::ADDR_SYNTH;
      wr_now  = access && s_q.pready && pwrite && pstrb[0];

      // apb: one wait state, write lands at the edge with pready high
      s_d.pready  = access && !s_q.pready;
      s_d.pslverr = access && !s_q.pready && !(hit_two || hit_set || hit_syn);
      s_d.prdata  = 32'h00000000;
      if (access && !s_q.pready && !pwrite)
      begin
         if (hit_two)
            s_d.prdata = {24'h000000, s_q.ctrl_two};
         else if (hit_set)
            s_d.prdata = {24'h000000, s_q.settings};
         else if (hit_syn)
            s_d.prdata = {24'h000000, s_q.synth};
      end
      // full byte stored, reserved bits included
      if (wr_now && hit_two)
         s_d.ctrl_two = pwdata[7:0];
      if (wr_now && hit_set)
         s_d.settings = pwdata[7:0];
      if (wr_now && hit_syn)
         s_d.synth = pwdata[7:0];

      // defaults from OTP once after reset release
      if (s_q.load_pend)
      begin
         s_d.ctrl_two  = otp_ctrl_two;
         s_d.settings  = otp_settings;
         s_d.synth     = otp_synth;
         s_d.load_pend = 1'b0;
      end

      // enable-pin gating of the level bit
      case (gcc_pkg::gcc_gate_t'(s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_GATE +: 2]))
         gcc_pkg::GCC_GATE_NONE: gated = s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_LEVEL];
         gcc_pkg::GCC_GATE_EN1:  gated = s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_LEVEL] && enable_pin_one;
         gcc_pkg::GCC_GATE_EN2:  gated = s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_LEVEL] && enable_pin_two;
         gcc_pkg::GCC_GATE_EN3:  gated = s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_LEVEL] && enable_pin_three;
         default:                gated = 1'b0;
      endcase

      // startup/shutdown delay in half-millisecond units
      scale = gated ? s_q.settings[gcc_pkg::POS_STARTUP_SCALE]
                    : s_q.settings[gcc_pkg::POS_SHUTDOWN_SCALE];
      code  = gated ? out_two_startup_code : out_two_shutdown_code;
      s_d.target = gated;
      if (gated != s_q.target)
      begin
         s_d.busy   = gated != s_q.level;
         s_d.remain = scale ? {code, 1'b0} : {1'b0, code};
         s_d.tick   = '0;
      end
      else if (s_q.busy)
      begin
         if (s_q.remain == 5'h00)
         begin
            s_d.level = s_q.target;
            s_d.busy  = 1'b0;
         end
         else if (s_q.tick == TW'(TICK_CYCLES - 1))
         begin
            s_d.tick   = '0;
            s_d.remain = s_q.remain - 5'h01;
         end
         else
            s_d.tick = s_q.tick + TW'(1);
      end

      // pin two: clock input (released) or output two
      if (!s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_FUNC])
      begin
         s_d.pin_out = 1'b0;
         s_d.pin_oe  = 1'b0;
      end
      else if (s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_DRIVE])
      begin
         s_d.pin_out = 1'b0;
         s_d.pin_oe  = !s_q.level;
      end
      else
      begin
         s_d.pin_out = s_q.level;
         s_d.pin_oe  = 1'b1;
      end

      // pin one: power good or output one
      s_d.pin_one = s_q.ctrl_two[gcc_pkg::POS_OUT_ONE_FUNC] ? general_output_one
                                                             : power_good_one;

      // clock source and change event while synth runs
      s_d.ext_prev = ext_clock_present;
      s_d.use_ext  = s_q.synth[gcc_pkg::POS_PLL_ON] && ext_clock_present;
      s_d.evt      = s_q.synth[gcc_pkg::POS_PLL_ON] && (ext_clock_present != s_q.ext_prev);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_q           <= '0;
         s_q.ctrl_two  <= gcc_pkg::RST_CTRL_TWO;
         s_q.settings  <= gcc_pkg::RST_SETTINGS;
         s_q.synth     <= gcc_pkg::RST_SYNTH;
         s_q.load_pend <= 1'b1;
      end
      else
         s_q <= s_d;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pready                    = s_q.pready;
   assign prdata                    = s_q.prdata;
   assign pslverr                   = s_q.pslverr;
   assign out_two_pin_out           = s_q.pin_out;
   assign out_two_pin_oe            = s_q.pin_oe;
   assign out_one_pin_level         = s_q.pin_one;
   assign ext_clock_pin_pulldown    = s_q.settings[gcc_pkg::POS_EXT_CLK_PD];
   assign enable_pin_three_pulldown = s_q.settings[gcc_pkg::POS_ENABLE_PIN_THREE_PULLDOWN];
   assign enable_pin_two_pulldown   = s_q.settings[gcc_pkg::POS_ENABLE_PIN_TWO_PULLDOWN];
   assign enable_pin_one_pulldown   = s_q.settings[gcc_pkg::POS_ENABLE_PIN_ONE_PULLDOWN];
   assign thermal_warning_threshold = s_q.settings[gcc_pkg::POS_THERMAL_THR];
   assign spread_spectrum_on        = s_q.settings[gcc_pkg::POS_SPREAD];
   assign synth_running             = s_q.synth[gcc_pkg::POS_PLL_ON];
   assign ext_clock_selected        = s_q.use_ext;
   assign ext_clock_change_pulse    = s_q.evt;
   assign ext_clock_freq_code       = s_q.synth[gcc_pkg::POS_FREQ_CODE +: 5];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   a_pin_two_input: assert property (
      !s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_FUNC] |=> !out_two_pin_oe)
      else $error("pin two driven while in clock input mode");
   a_pin_one_select: assert property (
      !rst |=> out_one_pin_level == ($past(s_q.ctrl_two[gcc_pkg::POS_OUT_ONE_FUNC])
         ? $past(general_output_one) : $past(power_good_one)))
      else $error("pin one does not follow its function select");
   a_open_drain: assert property (
      s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_FUNC] && s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_DRIVE]
      |=> !out_two_pin_out && (out_two_pin_oe == !$past(s_q.level)))
      else $error("open-drain pin drives high");
   a_push_pull: assert property (
      s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_FUNC] && !s_q.ctrl_two[gcc_pkg::POS_OUT_TWO_DRIVE]
      |=> out_two_pin_oe && out_two_pin_out == $past(s_q.level))
      else $error("push-pull pin wrong");
   a_gate_enable: assert property (
      s_q.ctrl_two[2:1] == 2'h1 && !enable_pin_one |=> !s_q.target)
      else $error("gated target ignores enable pin one");
   a_gate_none: assert property (
      s_q.ctrl_two[2:1] == 2'h0 |=> s_q.target == $past(s_q.ctrl_two[0]))
      else $error("ungated target differs from level bit");
   a_delay_load: assert property (
      s_q.busy && !$past(s_q.busy) && s_q.target |-> s_q.remain ==
         ($past(s_q.settings[gcc_pkg::POS_STARTUP_SCALE]) ? {$past(out_two_startup_code), 1'b0}
                                                         : {1'b0, $past(out_two_startup_code)}))
      else $error("startup delay count not scaled");
   a_delay_done: assert property (
      s_q.busy && s_q.remain == 5'h00 && gated == s_q.target
      |=> !s_q.busy && s_q.level == $past(s_q.target))
      else $error("delayed level not applied at end of delay");
   a_rc_forced: assert property (
      !s_q.synth[gcc_pkg::POS_PLL_ON] |=> !ext_clock_selected && !ext_clock_change_pulse)
      else $error("external clock used with synth off");
   a_ext_follow: assert property (
      s_q.synth[gcc_pkg::POS_PLL_ON] |=> ext_clock_selected == $past(ext_clock_present))
      else $error("clock source does not follow external clock");
   a_clock_event: assert property (
      s_q.synth[gcc_pkg::POS_PLL_ON] && ext_clock_present != s_q.ext_prev
      |=> ext_clock_change_pulse
          ##1 ($past(ext_clock_present == s_q.ext_prev) -> !ext_clock_change_pulse))
      else $error("missing clock change pulse");
   a_otp_load: assert property (
      !rst && s_q.load_pend |=> s_q.ctrl_two == $past(otp_ctrl_two)
         && s_q.settings == $past(otp_settings) && s_q.synth == $past(otp_synth))
      else $error("OTP defaults not loaded");
   a_unmapped_error: assert property (
      psel && penable && !s_q.pready && !(hit_two || hit_set || hit_syn) |=> pready && pslverr)
      else $error("unmapped access not flagged");

   // ----------------------------------------------------------------
   // assertions: bus answer, register access, enable-pin gating and delay counter
   // ----------------------------------------------------------------
   a_ready_wait: assert property (
      psel && penable && !pready |=> pready)
      else $error("no answer after one wait state");
   a_ready_pulse: assert property (
      pready |=> !pready)
      else $error("pready high for more than one cycle");
   a_idle_quiet: assert property (
      !(psel && penable) |=> !pready && !pslverr && prdata == 32'h00000000)
      else $error("answer without an access cycle");
   a_mapped_ok: assert property (
      psel && penable && !pready && (hit_two || hit_set || hit_syn) |=> !pslverr)
      else $error("error flag on a mapped register");
   a_unmapped_zero: assert property (
      psel && penable && !pready && !(hit_two || hit_set || hit_syn) |=> prdata == 32'h00000000)
      else $error("unmapped read returns data");
   a_read_two: assert property (
      psel && penable && !pready && !pwrite && hit_two
      |=> prdata == {24'h000000, $past(s_q.ctrl_two)})
      else $error("read data differs from pin control register");
   a_read_settings: assert property (
      psel && penable && !pready && !pwrite && hit_set
      |=> prdata == {24'h000000, $past(s_q.settings)})
      else $error("read data differs from settings register");
   a_read_synth: assert property (
      psel && penable && !pready && !pwrite && hit_syn
      |=> prdata == {24'h000000, $past(s_q.synth)})
      else $error("read data differs from synth register");
   a_write_two: assert property (
      psel && penable && pready && pwrite && pstrb[0] && hit_two && !s_q.load_pend
      |=> s_q.ctrl_two == $past(pwdata[7:0]))
      else $error("write to pin control register lost");
   a_write_settings: assert property (
      psel && penable && pready && pwrite && pstrb[0] && hit_set && !s_q.load_pend
      |=> s_q.settings == $past(pwdata[7:0]))
      else $error("write to settings register lost");
   a_write_synth: assert property (
      psel && penable && pready && pwrite && pstrb[0] && hit_syn && !s_q.load_pend
      |=> s_q.synth == $past(pwdata[7:0]))
      else $error("write to synth register lost");
   a_refused_write: assert property (
      psel && penable && pready && pwrite && !s_q.load_pend && (!pstrb[0] || pslverr)
      |=> $stable(s_q.ctrl_two) && $stable(s_q.settings) && $stable(s_q.synth))
      else $error("refused write changed a register");

   a_gate_two: assert property (
      s_q.ctrl_two[2:1] == 2'h2 && !enable_pin_two |=> !s_q.target)
      else $error("gated target ignores enable pin two");
   a_gate_three: assert property (
      s_q.ctrl_two[2:1] == 2'h3 && !enable_pin_three |=> !s_q.target)
      else $error("gated target ignores enable pin three");
   a_gate_pass: assert property (
      s_q.ctrl_two[2:0] == 3'h3 && enable_pin_one |=> s_q.target)
      else $error("gated target blocked while enable pin one is high");
   a_delay_cancel: assert property (
      s_q.busy && gated == s_q.level |=> !s_q.busy)
      else $error("delay not cancelled when target returns");
   a_shutdown_load: assert property (
      s_q.busy && !$past(s_q.busy) && !s_q.target |-> s_q.remain ==
         ($past(s_q.settings[6]) ? {$past(out_two_shutdown_code), 1'b0}
                                 : {1'b0, $past(out_two_shutdown_code)}))
      else $error("shutdown delay count not scaled");
   a_delay_step: assert property (
      s_q.busy && s_q.remain != 5'h00 && s_q.tick == TW'(TICK_CYCLES - 1)
      && gated == s_q.target |=> s_q.remain == $past(s_q.remain) - 5'h01)
      else $error("delay unit not counted down");
   a_level_hold: assert property (
      !s_q.busy |=> s_q.level == $past(s_q.level))
      else $error("output level moved without a delay");
   a_tick_range: assert property (
      s_q.tick < TW'(TICK_CYCLES))
      else $error("delay tick counter out of range");

   // ----------------------------------------------------------------
   // cover properties
   // ----------------------------------------------------------------
   c_pin_two_high: cover property (out_two_pin_oe && out_two_pin_out);
   c_strobe_off:   cover property (psel && penable && pready && pwrite && !pstrb[0]);
   c_clock_event:  cover property (ext_clock_change_pulse);
   c_long_delay:   cover property (s_q.busy && s_q.settings[7] ##1 !s_q.busy);
   c_write_read:   cover property (pready && psel && pwrite ##[1:4] pready && !pwrite);

endmodule

// *** testbench/gcc_config_regs_tb.sv ***
// testbench: register access, pin functions, delays and clock source of the config bank
`timescale 1ns/1ps
module gcc_config_regs_tb;
   localparam int TICK = 4;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, otp_ctrl_two, otp_settings, otp_synth;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb, out_two_startup_code, out_two_shutdown_code;
   logic        enable_pin_one, enable_pin_two, enable_pin_three;
   logic        power_good_one, general_output_one, ext_clock_present;
   logic        out_two_pin_out, out_two_pin_oe, out_one_pin_level, ext_clock_pin_pulldown;
   logic        enable_pin_one_pulldown, enable_pin_two_pulldown, enable_pin_three_pulldown;
   logic        thermal_warning_threshold, spread_spectrum_on, synth_running;
   logic        ext_clock_selected, ext_clock_change_pulse, er, s, up;
   logic [4:0]  ext_clock_freq_code;
   int          err_total, checks_done, pulses, c, d;

   gcc_config_regs #(.TICK_CYCLES(TICK)) i_gcc_config_regs (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .otp_ctrl_two(otp_ctrl_two), .otp_settings(otp_settings),
      .otp_synth(otp_synth), .enable_pin_one(enable_pin_one), .enable_pin_two(enable_pin_two),
      .enable_pin_three(enable_pin_three), .power_good_one(power_good_one),
      .general_output_one(general_output_one), .ext_clock_present(ext_clock_present),
      .out_two_startup_code(out_two_startup_code), .out_two_shutdown_code(out_two_shutdown_code),
      .out_two_pin_out(out_two_pin_out), .out_two_pin_oe(out_two_pin_oe),
      .out_one_pin_level(out_one_pin_level), .ext_clock_pin_pulldown(ext_clock_pin_pulldown),
      .enable_pin_one_pulldown(enable_pin_one_pulldown),
      .enable_pin_two_pulldown(enable_pin_two_pulldown),
      .enable_pin_three_pulldown(enable_pin_three_pulldown),
      .thermal_warning_threshold(thermal_warning_threshold),
      .spread_spectrum_on(spread_spectrum_on), .synth_running(synth_running),
      .ext_clock_selected(ext_clock_selected), .ext_clock_change_pulse(ext_clock_change_pulse),
      .ext_clock_freq_code(ext_clock_freq_code));

   always #2.5 clock = ~clock;

   always @(posedge clock)
      if (ext_clock_change_pulse === 1'b1)
         pulses++;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                      input logic [3:0] st);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h000000, wd};
      pstrb   <= st;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         err_total++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge: next call never reassigns psel in this time step
      @(posedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      apb(1'b1, a, wd, 4'hF);
   endtask

   task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00, 4'hF);
      check(name, rd, exp);
      check("read error flag", {31'h00000000, er}, 32'h0);
   endtask

   task automatic settle;
      repeat (8) @(posedge clock);
   endtask

   task automatic wait_pin(input logic exp, input int lo, input int hi);
      int n;
      n = 0;
      while (out_two_pin_out !== exp && n < hi + 20)
      begin
         @(posedge clock);
         n++;
      end
      check("pin delay in range", 32'(n >= lo && n <= hi), 32'h1);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {clock, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {enable_pin_one, enable_pin_two, enable_pin_three, general_output_one} = '0;
      {out_two_startup_code, out_two_shutdown_code, ext_clock_present} = '0;
      err_total = 0;
      checks_done = 0;
      pulses = 0;
      power_good_one = 1'b1;
      otp_ctrl_two = 8'h0B;
      otp_settings = 8'hC3;
      otp_synth = 8'h05;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      check("reset pulldowns", {ext_clock_pin_pulldown, enable_pin_three_pulldown,
            enable_pin_two_pulldown, enable_pin_one_pulldown}, 32'hF);
      check("reset freq code", ext_clock_freq_code, 32'h2);
      check("reset pin enable", out_two_pin_oe, 32'h0);
      rst <= 1'b0;
      repeat (2) @(posedge clock);
      rdc("otp ctrl two", 8'h40, 32'h0B);
      rdc("otp settings", 8'h44, 32'hC3);
      rdc("otp synth", 8'h48, 32'h05);
      check("otp settings pins", {ext_clock_pin_pulldown, enable_pin_three_pulldown,
            enable_pin_two_pulldown, enable_pin_one_pulldown, thermal_warning_threshold,
            spread_spectrum_on}, 32'h03);
      wr(8'h44, 8'h3C);
      check("settings pins", {ext_clock_pin_pulldown, thermal_warning_threshold,
            spread_spectrum_on}, 32'h4);
      apb(1'b1, 8'h44, 8'h00, 4'h0);
      rdc("strobe ignored", 8'h44, 32'h3C);
      apb(1'b0, 8'h4C, 8'h00, 4'hF);
      check("unmapped read", {er, rd[30:0]}, 32'h80000000);
      wr(8'h48, 8'h97); // fraction bit zero, synth off
      rdc("reserved and freq", 8'h48, 32'h97);
      check("freq code max", ext_clock_freq_code, 32'h17);
      wr(8'h40, 8'hC1);
      settle();
      rdc("ctrl two reserved", 8'h40, 32'hC1);
      check("clock input mode", out_two_pin_oe, 32'h0);
      check("pin one power good", out_one_pin_level, 32'h1);
      wr(8'h40, 8'h10);
      settle();
      check("pin one output", out_one_pin_level, 32'h0);
      wr(8'h40, 8'h29);
      settle();
      check("open drain high", {out_two_pin_out, out_two_pin_oe}, 32'h0);
      wr(8'h40, 8'h28);
      settle();
      check("open drain low", {out_two_pin_out, out_two_pin_oe}, 32'h1);
      wr(8'h40, 8'h20);
      settle();
      check("push pull low", {out_two_pin_out, out_two_pin_oe}, 32'h1);
      // startup and shutdown delays, other scale bit and code set opposite
      for (int k = 0; k < 4; k++)
      begin
         s = k[1];
         up = ~k[0];
         c = up ? 3 : 15;
         wr(8'h44, {up ? s : ~s, up ? ~s : s, 6'h3C});
         out_two_startup_code  <= up ? 4'(c) : 4'(15 - c);
         out_two_shutdown_code <= up ? 4'(15 - c) : 4'(c);
         d = c * (s ? 2 : 1) * TICK;
         wr(8'h40, {7'h10, up});
         wait_pin(up, d, d + 6);
      end
      out_two_startup_code  <= 4'h0;
      out_two_shutdown_code <= 4'h0;
      wr(8'h40, 8'h21);
      wait_pin(1'b1, 0, 6);
      for (int g = 1; g < 4; g++)
      begin
         {enable_pin_three, enable_pin_two, enable_pin_one} <= 3'(1 << (g - 1));
         wr(8'h40, 8'(8'h21 | (g << 1)));
         settle();
         check("gated high", out_two_pin_out, 32'h1);
         {enable_pin_three, enable_pin_two, enable_pin_one} <= ~3'(1 << (g - 1));
         settle();
         check("gated low", out_two_pin_out, 32'h0);
      end
      ext_clock_present <= 1'b1;
      wr(8'h48, 8'h02);
      settle();
      check("synth off", {synth_running, ext_clock_selected}, 32'h0);
      ext_clock_present <= 1'b0;
      settle();
      check("no event synth off", pulses, 32'h0);
      wr(8'h48, 8'h42);
      ext_clock_present <= 1'b1;
      settle();
      check("synth on", {synth_running, ext_clock_selected}, 32'h3);
      check("event on appear", pulses, 32'h1);
      ext_clock_present <= 1'b0;
      settle();
      check("fall back", ext_clock_selected, 32'h0);
      check("event on loss", pulses, 32'h2);
      stop_test();
   end

   initial
   begin
      repeat (100000) @(posedge clock);
      err_total++;
      stop_test();
   end
endmodule
